// file: spmc_core.sv
// Serial peripheral core: master/slave byte shifter with register port
`timescale 1ns/1ps
`include "spmc_defs.svh"
module spmc_core
  import spmc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // System
  input wire logic dbg_halt,
  input wire logic global_irq_en,
  output logic irq,
  // Port direction settings, high means output
  input wire logic dir_mosi,
  input wire logic dir_miso,
  input wire logic dir_sck,
  input wire logic dir_ss,
  // Serial pins
  input wire logic sck_pin,
  output logic sck_drv,
  output logic sck_oe_n,
  input wire logic mosi_pin,
  output logic mosi_drv,
  output logic mosi_oe_n,
  input wire logic miso_pin,
  output logic miso_drv,
  output logic miso_oe_n,
  input wire logic ss_pin
);
  spmc_regs_t q, n;
  logic [3:0] pin_s;
  logic tick, run;
  logic en, mst, slv, cpol, cpha, lsbf, bufon, busy;
  logic ev, lead, din, done, got, n_mst, n_slv;
  logic [7:0] rx_byte, wsh;
  logic [2:0] set_f, clr_f;

  function automatic logic first_bit(input logic [7:0] v, input logic lsb);
    first_bit = lsb ? v[0] : v[7];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] v,
                                          input logic b, input logic lsb);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // ==========================================================
  // Pin synchronisers and master clock divider
  spmc_sync #(.W(4)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d({ss_pin, sck_pin, miso_pin, mosi_pin}),
    .q(pin_s)
  );

  // Divider only runs while a master byte is in flight
  assign run = mst & (q.st == ST_SHIFT) & ~dbg_halt;

  spmc_clkgen u_clkgen (
    .clock(clock),
    .nrst(nrst),
    .run(run),
    .clock_prescaler_select(q.control_reg_a[`SPMC_A_PRESCALER]),
    .double_speed_select(q.control_reg_a[`SPMC_A_DOUBLE]),
    .tick(tick)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    n = q;
    en = q.control_reg_a[`SPMC_A_ENABLE];
    mst = en & q.control_reg_a[`SPMC_A_MASTER];
    slv = en & ~q.control_reg_a[`SPMC_A_MASTER];
    cpol = q.control_reg_b[`SPMC_B_CPOL];
    cpha = q.control_reg_b[`SPMC_B_CPHA];
    lsbf = q.control_reg_a[`SPMC_A_BITORDER];
    bufon = q.control_reg_b[`SPMC_B_BUFON];
    // Synchronised MISO needs half periods of three clocks or more
    din = mst ? pin_s[`SPMC_P_MISO] : pin_s[`SPMC_P_MOSI];
    ev = 1'b0;
    lead = 1'b0;
    done = 1'b0;
    got = 1'b0;
    busy = 1'b0;
    rx_byte = `SPMC_RST_BYTE;
    wsh = `SPMC_RST_BYTE;
    set_f = '0;
    clr_f = '0;
    n.rdata = `SPMC_RST_BYTE;
    n.sck_prev = pin_s[`SPMC_P_SCK];
    if (q.st == ST_IDLE) begin
      n.sck_lvl = cpol;
    end
    // Edge sources; nothing moves while the CPU is halted
    if (!dbg_halt) begin
      if (mst && q.st == ST_SHIFT && tick) begin
        ev = 1'b1;
        lead = (q.sck_lvl == cpol);
        n.sck_lvl = ~q.sck_lvl;
      end
      if (slv) begin
        if (pin_s[`SPMC_P_SS]) begin
          // Deselect aborts any partial byte
          n.st = ST_IDLE;
          n.edge_cnt = '0;
        end else if (pin_s[`SPMC_P_SCK] != q.sck_prev) begin
          ev = 1'b1;
          lead = (pin_s[`SPMC_P_SCK] != cpol);
        end
      end
    end
    // Shift engine: leading edge samples or presents, trailing edge shifts
    if (ev) begin
      n.st = ST_SHIFT;
      n.edge_cnt = q.edge_cnt + 5'h01;
      if (lead) begin
        if (cpha) begin
          n.out_bit = first_bit(q.shreg, lsbf);
        end else begin
          n.in_bit = din;
        end
      end else begin
        wsh = shift_in(q.shreg, cpha ? din : q.in_bit, lsbf);
        n.shreg = wsh;
        n.out_bit = first_bit(wsh, lsbf);
        if (q.edge_cnt == `SPMC_LAST_EDGE) begin
          done = 1'b1;
          got = 1'b1;
          rx_byte = wsh;
          n.st = ST_IDLE;
          n.edge_cnt = '0;
          n.sh_pend = 1'b0;
          set_f[`SPMC_F_DONE] = 1'b1;
          if (bufon && q.tx_full) begin
            n.shreg = q.tx_buf;
            n.out_bit = first_bit(q.tx_buf, lsbf);
            n.tx_full = 1'b0;
            n.sh_pend = ~mst;
            if (mst) begin
              n.st = ST_SHIFT;
            end
          end else if (bufon) begin
            set_f[`SPMC_F_TXC] = 1'b1;
          end
        end
      end
    end
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `SPMC_ADDR_CTRLA: n.control_reg_a = reg_wdata;
        `SPMC_ADDR_CTRLB: n.control_reg_b = reg_wdata;
        `SPMC_ADDR_MASK: n.irq_mask = reg_wdata[2:0];
        `SPMC_ADDR_FLAGS: clr_f = reg_wdata[2:0];
        `SPMC_ADDR_DATA: begin
          busy = (n.st == ST_SHIFT) | (bufon & n.sh_pend);
          if (!busy) begin
            n.shreg = reg_wdata;
            n.out_bit = first_bit(reg_wdata, lsbf);
            n.sh_pend = ~mst;
            if (mst) begin
              n.st = ST_SHIFT;
              n.edge_cnt = '0;
              n.sck_lvl = cpol;
            end
          end else if (bufon && !n.tx_full) begin
            n.tx_buf = reg_wdata;
            n.tx_full = 1'b1;
          end else begin
            set_f[`SPMC_F_COLL] = 1'b1;
            // An unbuffered master overwrites the byte in flight; otherwise the write is dropped
            if (!bufon && mst) begin
              n.shreg = reg_wdata;
            end
          end
        end
        default: ;
      endcase
    end
    // Register reads, answered next cycle
    if (reg_rd) begin
      case (reg_addr)
        `SPMC_ADDR_CTRLA: n.rdata = q.control_reg_a;
        `SPMC_ADDR_CTRLB: n.rdata = q.control_reg_b;
        `SPMC_ADDR_MASK: n.rdata = {5'h00, q.irq_mask};
        `SPMC_ADDR_FLAGS: begin
          n.rdata = {3'h0, q.st == ST_SHIFT, q.tx_full,
                     q.interrupt_flag_register};
        end
        `SPMC_ADDR_DATA: begin
          if (bufon) begin
            n.rdata = q.rx_second;
            if (q.rx_count != 2'h0) begin
              n.rx_second = q.rx_first;
              n.rx_count = q.rx_count - 2'h1;
            end
          end else begin
            n.rdata = q.rx_first;
          end
        end
        default: n.rdata = `SPMC_RST_BYTE;
      endcase
    end
    // Receive path; a full two-entry queue drops the new byte
    if (got) begin
      if (!bufon) begin
        n.rx_first = rx_byte;
      end else if (n.rx_count == 2'h0) begin
        n.rx_second = rx_byte;
        n.rx_count = 2'h1;
      end else if (n.rx_count == 2'h1) begin
        n.rx_first = rx_byte;
        n.rx_count = 2'h2;
      end
    end
    // Another master pulled SS low: fall back to slave
    if (!dbg_halt && mst && !q.control_reg_b[`SPMC_B_SELDIS]
        && !dir_ss && !pin_s[`SPMC_P_SS]) begin
      n.control_reg_a[`SPMC_A_MASTER] = 1'b0;
      n.st = ST_IDLE;
      n.edge_cnt = '0;
      n.sh_pend = 1'b0;
      set_f[`SPMC_F_DONE] = 1'b1;
    end
    // Set beats clear in the same cycle
    n.interrupt_flag_register = (q.interrupt_flag_register & ~clr_f) | set_f;
    n.irq = global_irq_en
            & |(n.interrupt_flag_register & n.irq_mask);
    // Pin drive follows the next mode so outputs stay in step
    n_mst = n.control_reg_a[`SPMC_A_ENABLE]
            & n.control_reg_a[`SPMC_A_MASTER];
    n_slv = n.control_reg_a[`SPMC_A_ENABLE]
            & ~n.control_reg_a[`SPMC_A_MASTER];
    n.sck_drv = n.sck_lvl;
    n.mosi_drv = n.out_bit;
    n.miso_drv = n.out_bit;
    n.sck_oe_n = ~(n_mst & dir_sck);
    n.mosi_oe_n = ~(n_mst & dir_mosi);
    n.miso_oe_n = ~(n_slv & dir_miso & ~pin_s[`SPMC_P_SS]);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.sck_oe_n <= 1'b1;
      q.mosi_oe_n <= 1'b1;
      q.miso_oe_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign irq = q.irq;
  assign sck_drv = q.sck_drv;
  assign sck_oe_n = q.sck_oe_n;
  assign mosi_drv = q.mosi_drv;
  assign mosi_oe_n = q.mosi_oe_n;
  assign miso_drv = q.miso_drv;
  assign miso_oe_n = q.miso_oe_n;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  master_miso_in_a: assert property (
    q.control_reg_a[`SPMC_A_ENABLE] && q.control_reg_a[`SPMC_A_MASTER]
    |-> q.miso_oe_n && (q.mosi_oe_n == ~$past(dir_mosi)))
    else $error("master drives miso or ignores mosi direction");

  miso_select_a: assert property (
    !q.miso_oe_n |-> $past(!pin_s[`SPMC_P_SS]) && $past(dir_miso))
    else $error("slave miso driven while deselected");

  halt_freeze_a: assert property (
    dbg_halt && !reg_wr |=> $stable(q.edge_cnt) && $stable(q.st))
    else $error("shift state moved during debug halt");

  master_start_a: assert property (
    reg_wr && reg_addr == `SPMC_ADDR_DATA && mst && q.st == ST_IDLE
    && !(!q.control_reg_b[`SPMC_B_SELDIS] && !dir_ss
    && !pin_s[`SPMC_P_SS])
    |=> q.st == ST_SHIFT && q.edge_cnt == 5'h00)
    else $error("data write did not start master transfer");

  byte_flag_a: assert property (
    done |=> q.interrupt_flag_register[`SPMC_F_DONE]
    ##0 q.edge_cnt == 5'h00)
    else $error("byte end did not set transfer flag");

  seldis_keep_a: assert property (
    mst && q.control_reg_b[`SPMC_B_SELDIS] && !reg_wr
    |=> q.control_reg_a[`SPMC_A_MASTER])
    else $error("master dropped with select pin disabled");

  forced_drop_a: assert property (
    mst && !dbg_halt && !q.control_reg_b[`SPMC_B_SELDIS] && !dir_ss
    && !pin_s[`SPMC_P_SS]
    |=> !q.control_reg_a[`SPMC_A_MASTER]
    && q.interrupt_flag_register[`SPMC_F_DONE]
    && q.mosi_oe_n && q.sck_oe_n)
    else $error("low select did not force slave mode");

  irq_enable_a: assert property (
    irq |-> $past(global_irq_en)
    && $past(|(n.interrupt_flag_register & n.irq_mask)))
    else $error("interrupt raised without both enables");

  collision_a: assert property (
    reg_wr && reg_addr == `SPMC_ADDR_DATA && !bufon && mst
    && q.st == ST_SHIFT && !tick
    |=> q.interrupt_flag_register[`SPMC_F_COLL]
    && q.shreg == $past(reg_wdata))
    else $error("premature write did not flag collision");

  slave_pins_in_a: assert property (
    q.control_reg_a[`SPMC_A_ENABLE] && !q.control_reg_a[`SPMC_A_MASTER]
    |-> q.sck_oe_n && q.mosi_oe_n)
    else $error("slave drives sck or mosi");

  unbuf_load_a: assert property (
    reg_wr && reg_addr == `SPMC_ADDR_DATA && !bufon && !busy
    |=> q.shreg == $past(reg_wdata))
    else $error("unbuffered data write missed shift register");

  unbuf_read_a: assert property (
    reg_rd && reg_addr == `SPMC_ADDR_DATA && !bufon
    |=> reg_rdata == $past(q.rx_first))
    else $error("unbuffered data read missed first buffer");

  buf_read_a: assert property (
    reg_rd && reg_addr == `SPMC_ADDR_DATA && bufon
    |=> reg_rdata == $past(q.rx_second))
    else $error("buffered data read missed second buffer");

  master_byte_c: cover property (done && mst);
  slave_byte_c: cover property (done && slv);
  forced_drop_c: cover property (
    mst ##1 !q.control_reg_a[`SPMC_A_MASTER] && q.control_reg_a[0]);
  buffer_reload_c: cover property (done && bufon && q.tx_full);
endmodule

// file: spmc_defs.svh
// Constants for the serial peripheral core: offsets, fields, resets, timing
// What this block does
// - One 8-bit shift register shifts a bit out and in per step.
// - Data write loads shift register when free; buffered, a busy write fills the transmit buffer if it is empty.
// - Data read returns first receive buffer unbuffered, second when buffered.
// - Master makes SCK from its divider; slave samples synchronised SCK edges.
// - Enabled master forces MISO input; enabled slave forces MOSI, SCK, SS input.
// - User-directed pins other than SS are driven by the core when output, untouched when input.
// - Slave drives an output MISO only while SS is low, else tristate.
// - Operation halts while the CPU is debug-halted, runs in run-time debug.
// - Master data write starts the clock generator and shifts eight bits.
// - Master sets the transfer flag once the byte is shifted out.
// - Master with select-pin disable set ignores the SS pin entirely.
// - Master with SS as output is unaffected by the SS pin level.
// - Master with SS input going low clears master bit and becomes slave.
// - That forced drop sets the transfer flag; interrupt needs both enables.
// - Unbuffered master write during a transfer corrupts data, sets collision.
`ifndef SPMC_DEFS_SVH
`define SPMC_DEFS_SVH
// ==========================================================
// Register offsets
`define SPMC_ADDR_CTRLA 4'h0
`define SPMC_ADDR_CTRLB 4'h1
`define SPMC_ADDR_MASK 4'h2
`define SPMC_ADDR_FLAGS 4'h3
`define SPMC_ADDR_DATA 4'h4
// ==========================================================
// Field positions
`define SPMC_A_ENABLE 0
`define SPMC_A_PRESCALER 2:1
`define SPMC_A_DOUBLE 4
`define SPMC_A_MASTER 5
`define SPMC_A_BITORDER 6
`define SPMC_B_CPHA 0
`define SPMC_B_CPOL 1
`define SPMC_B_SELDIS 2
`define SPMC_B_BUFWAIT 6
`define SPMC_B_BUFON 7
`define SPMC_F_DONE 0
`define SPMC_F_COLL 1
`define SPMC_F_TXC 2
`define SPMC_P_MOSI 0
`define SPMC_P_MISO 1
`define SPMC_P_SCK 2
`define SPMC_P_SS 3
// ==========================================================
// Reset values and timing
`define SPMC_RST_BYTE 8'h00
`define SPMC_LAST_EDGE 5'h0F
`define SPMC_HALF_DIV4 7'h02
`define SPMC_HALF_DIV16 7'h08
`define SPMC_HALF_DIV64 7'h20
`define SPMC_HALF_DIV128 7'h40
`endif

// file: spmc_pkg.sv
// Types shared by the serial peripheral core modules
package spmc_pkg;
  typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} spmc_state_t;
  typedef struct packed {
    spmc_state_t st;
    logic [7:0] control_reg_a;
    logic [7:0] control_reg_b;
    logic [2:0] irq_mask;
    logic [2:0] interrupt_flag_register;
    logic [7:0] shreg;
    logic [7:0] tx_buf;
    logic tx_full;
    logic sh_pend;
    logic [7:0] rx_first;
    logic [7:0] rx_second;
    logic [1:0] rx_count;
    logic [4:0] edge_cnt;
    logic sck_lvl;
    logic sck_prev;
    logic in_bit;
    logic out_bit;
    logic [7:0] rdata;
    logic irq;
    logic sck_drv;
    logic sck_oe_n;
    logic mosi_drv;
    logic mosi_oe_n;
    logic miso_drv;
    logic miso_oe_n;
  } spmc_regs_t;
  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } spmc_div_t;
endpackage

// file: spmc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module spmc_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spmc_sync_t;
  spmc_sync_t r, n;
  always_comb begin
    n.s1 = d;
    n.s2 = r.s1;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign q = r.s2;
endmodule

// file: spmc_clkgen.sv
// Master SCK half-period tick generator
`timescale 1ns/1ps
`include "spmc_defs.svh"
module spmc_clkgen
  import spmc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic [1:0] clock_prescaler_select,
  input wire logic double_speed_select,
  // Tick, one cycle per SCK half period
  output logic tick
);
  spmc_div_t r, n;
  logic [6:0] half;
  always_comb begin
    case (clock_prescaler_select)
      2'h0: half = `SPMC_HALF_DIV4;
      2'h1: half = `SPMC_HALF_DIV16;
      2'h2: half = `SPMC_HALF_DIV64;
      default: half = `SPMC_HALF_DIV128;
    endcase
    if (double_speed_select) begin
      half = half >> 1;
    end
    n = r;
    n.tick = 1'b0;
    if (!run) begin
      n.cnt = '0;
    end else if (r.cnt == half - 7'h01) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + 7'h01;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign tick = r.tick;
endmodule

// file: spmc_slave_model.sv
// Behavioural far-side peripheral answering master-mode transfers
`timescale 1ns/1ps
module spmc_slave_model (
  // Select and clock
  input wire logic sel_n,
  input wire logic sck,
  // Data
  input wire logic mosi,
  input wire logic [7:0] seed,
  output logic miso,
  output logic [7:0] rx_byte
);
  // ==========================================================
  // Mode 0 peer, most significant bit first
  logic [7:0] sh;
  logic [7:0] nxt;
  int n;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    sh = 8'h00;
    nxt = 8'h00;
    n = 0;
  end
  always @(negedge sel_n) begin
    nxt = seed;
    sh = seed;
    n = 0;
    miso = sh[7];
  end
  // Bit in and bit out share one shift step
  always @(posedge sck) begin
    if (!sel_n) begin
      sh = {sh[6:0], mosi};
      n++;
      if (n == 8) begin
        rx_byte = sh;
        n = 0;
        nxt = nxt + 8'h01;
        sh = nxt;
      end
    end
  end
  always @(negedge sck) if (!sel_n) miso = sh[7];
  // Released line must not look like valid data
  always @(posedge sel_n) miso = ~miso;
endmodule

// file: testbench.sv
// Self-checking bench for the serial peripheral core
`timescale 1ns/1ps
`include "spmc_defs.svh"
module testbench;
  localparam logic [3:0] A_CA = `SPMC_ADDR_CTRLA;
  localparam logic [3:0] A_CB = `SPMC_ADDR_CTRLB;
  localparam logic [3:0] A_MK = `SPMC_ADDR_MASK;
  localparam logic [3:0] A_FL = `SPMC_ADDR_FLAGS;
  localparam logic [3:0] A_DT = `SPMC_ADDR_DATA;
  logic clock, nrst, reg_wr, reg_rd, dbg_halt, global_irq_en;
  logic dir_mosi, dir_miso, dir_sck, dir_ss, ss_n, psel_n, tb_sck, tb_mosi;
  logic irq, sck_drv, sck_oe_n, mosi_drv, mosi_oe_n, miso_drv, miso_oe_n;
  logic pm_miso;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, seed, p_rx, got;
  wire sck_w, mosi_w, miso_w;
  int failures, num_checks;
  // ==========================================================
  // Pin levels from all drivers
  assign sck_w = sck_oe_n ? tb_sck : sck_drv;
  assign mosi_w = mosi_oe_n ? tb_mosi : mosi_drv;
  assign miso_w = miso_oe_n ? pm_miso : miso_drv;
  spmc_core i_dut (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dbg_halt(dbg_halt),
    .global_irq_en(global_irq_en), .irq(irq), .dir_mosi(dir_mosi),
    .dir_miso(dir_miso), .dir_sck(dir_sck), .dir_ss(dir_ss),
    .sck_pin(sck_w), .sck_drv(sck_drv), .sck_oe_n(sck_oe_n),
    .mosi_pin(mosi_w), .mosi_drv(mosi_drv), .mosi_oe_n(mosi_oe_n),
    .miso_pin(miso_w), .miso_drv(miso_drv), .miso_oe_n(miso_oe_n),
    .ss_pin(ss_n)
  );
  spmc_slave_model i_peer (
    .sel_n(psel_n), .sck(sck_w), .mosi(mosi_w), .seed(seed),
    .miso(pm_miso), .rx_byte(p_rx)
  );
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // ==========================================================
  // Bus and compare tasks
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_byte({7'h00, g}, {7'h00, e});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chkr(input logic [3:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk_byte(v & m, e);
  endtask
  task automatic wait_flag(input int b);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 300 && !v[b]; i++) rd(A_FL, v);
    if (v[b] !== 1'b1) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic clr_flags;
    wr(A_FL, 8'h07);
    @(posedge clock);
    #1 chk_bit(irq, 1'b0);
  endtask
  task automatic mxfer(input logic [7:0] tx, input logic [7:0] ep,
                       input logic [7:0] ec);
    @(posedge clock);
    psel_n <= 1'b0;
    wr(A_DT, tx);
    wait_flag(0);
    chk_byte(p_rx, ep);
    chk_bit(irq, 1'b1);
    chkr(A_DT, 8'hFF, ec);
    clr_flags();
    psel_n <= 1'b1;
  endtask
  // Far master at the link rate; bits change on the falling edge, sampled on rise
  task automatic xfer_slave(input logic [7:0] m, output logic [7:0] s);
    for (int i = 7; i >= 0; i--) begin
      tb_mosi = m[i];
      #100;
      tb_sck = 1'b1;
      s[i] = miso_w;
      #100;
      tb_sck = 1'b0;
    end
    tb_mosi = ~tb_mosi;
  endtask
  initial begin
    #2000000;
    failures++;
    complete_run();
  end
  // ==========================================================
  // Main sequence
  initial begin
    failures = 0;
    num_checks = 0;
    {nrst, reg_wr, reg_rd, dbg_halt, tb_sck, tb_mosi, dir_ss} = 7'h00;
    {global_irq_en, dir_mosi, dir_miso, dir_sck, ss_n, psel_n} = 6'h3F;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    seed = 8'h1E;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    chkr(A_CA, 8'hFF, 8'h00);
    chkr(A_FL, 8'hFF, 8'h00);
    chkr(4'hF, 8'hFF, 8'h00);
    wr(A_CB, 8'h00);
    wr(A_MK, 8'h01);
    // Half period of four clocks leaves room for the MISO synchroniser
    wr(A_CA, 8'h33);
    #1 chk_bit(miso_oe_n, 1'b1);
    chk_bit(mosi_oe_n, 1'b0);
    mxfer(8'hA5, 8'hA5, 8'h1E);
    wr(A_CA, 8'h73);
    mxfer(8'hC1, 8'h83, 8'h78);
    wr(A_CA, 8'h33);
    dir_mosi <= 1'b0;
    repeat (3) @(posedge clock);
    chk_bit(mosi_oe_n, 1'b1);
    dir_mosi <= 1'b1;
    psel_n <= 1'b0;
    wr(A_DT, 8'h11);
    wr(A_DT, 8'h22);
    wait_flag(0);
    chkr(A_FL, 8'h03, 8'h03);
    clr_flags();
    psel_n <= 1'b1;
    // Halted core must not clock out anything
    @(posedge clock);
    psel_n <= 1'b0;
    dbg_halt <= 1'b1;
    wr(A_DT, 8'h55);
    repeat (40) @(posedge clock);
    #1 chk_bit(sck_drv, 1'b0);
    chkr(A_FL, 8'h01, 8'h00);
    @(posedge clock);
    dbg_halt <= 1'b0;
    wait_flag(0);
    chk_byte(p_rx, 8'h55);
    clr_flags();
    psel_n <= 1'b1;
    wr(A_CB, 8'h80);
    @(posedge clock);
    psel_n <= 1'b0;
    wr(A_DT, 8'h81);
    wr(A_DT, 8'h42);
    wait_flag(2);
    chkr(A_FL, 8'h02, 8'h00);
    chk_byte(p_rx, 8'h42);
    chkr(A_DT, 8'hFF, 8'h1E);
    chkr(A_DT, 8'hFF, 8'h1F);
    clr_flags();
    psel_n <= 1'b1;
    wr(A_CB, 8'h04);
    ss_n <= 1'b0;
    repeat (8) @(posedge clock);
    chkr(A_CA, 8'h20, 8'h20);
    @(posedge clock);
    ss_n <= 1'b1;
    wr(A_CB, 8'h00);
    dir_ss <= 1'b1;
    ss_n <= 1'b0;
    repeat (8) @(posedge clock);
    chkr(A_CA, 8'h20, 8'h20);
    @(posedge clock);
    ss_n <= 1'b1;
    global_irq_en <= 1'b0;
    // Select must read high through the synchroniser before it counts
    repeat (4) @(posedge clock);
    dir_ss <= 1'b0;
    repeat (4) @(posedge clock);
    chkr(A_CA, 8'h20, 8'h20);
    repeat (2) @(posedge clock);
    ss_n <= 1'b0;
    repeat (8) @(posedge clock);
    chkr(A_CA, 8'h20, 8'h00);
    chkr(A_FL, 8'h01, 8'h01);
    chk_bit(irq, 1'b0);
    @(posedge clock);
    global_irq_en <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk_bit(irq, 1'b1);
    chk_bit(mosi_oe_n, 1'b1);
    chk_bit(sck_oe_n, 1'b1);
    clr_flags();
    // Slave byte with the bench as far master
    @(posedge clock);
    ss_n <= 1'b1;
    repeat (6) @(posedge clock);
    chk_bit(miso_oe_n, 1'b1);
    wr(A_DT, 8'h5A);
    ss_n <= 1'b0;
    repeat (6) @(posedge clock);
    chk_bit(miso_oe_n, 1'b0);
    #7 xfer_slave(8'hC3, got);
    chk_byte(got, 8'h5A);
    repeat (6) @(posedge clock);
    ss_n <= 1'b1;
    wait_flag(0);
    chkr(A_DT, 8'hFF, 8'hC3);
    repeat (4) @(posedge clock);
    chk_bit(miso_oe_n, 1'b1);
    chkr(A_CA, 8'h20, 8'h00);
    wr(A_CA, 8'h33);
    chkr(A_CA, 8'h20, 8'h20);
    complete_run();
  end
endmodule
